// ### bench/acd_config_chk.sv
`timescale 1ns/1ps
// Ties the decoded controls, except level one-hot, connected, illegal flag and step, to the applied word
module acd_config_chk
    import acd_pkg::*;
(
    input wire logic clock_i, // Clock
    input wire logic arst_n_i, // Reset
    input wire logic sel_n_i, // Select
    input wire acd_pkg::acd_ctrl_s ctrl_o, // Controls
    input wire logic [acd_pkg::WORD_W-1:0] word_o // Word
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    property p_sd; ctrl_o.power_down == word_o[SHUTDOWN_BIT]; endproperty
    a_sd: assert property (p_sd) else $error("shutdown");
    property p_fs; word_o[2:0] != 3'h7 |-> ctrl_o.filter_path_switch == word_o[10]; endproperty
    a_fs: assert property (p_fs) else $error("filter");
    property p_ex; word_o[2:0] == 3'h7 |-> ctrl_o.filter_path_switch; endproperty
    a_ex: assert property (p_ex) else $error("forced");
    property p_rs; $changed(word_o) |-> ctrl_o.internal_ratio_switch == (word_o[2:0] != 3'h7);
    endproperty
    a_rs: assert property (p_rs) else $error("ratio");
    property p_tg; ctrl_o.source_to_negative == word_o[11]; endproperty
    a_tg: assert property (p_tg) else $error("target");
    property p_lv; ctrl_o.source_powered == (word_o[14:12] inside {[3'h1:3'h6]}); endproperty
    a_lv: assert property (p_lv) else $error("level");
    property p_rt; {ctrl_o.input_invert, ctrl_o.route} == word_o[8:6]; endproperty
    a_rt: assert property (p_rt) else $error("route");
    property p_bw; ctrl_o.bandwidth_level == (word_o[5] ? 3'h4 : {1'b0, word_o[4:3]}); endproperty
    a_bw: assert property (p_bw) else $error("trim");
    property p_wh; (!sel_n_i)[*6] |-> $stable(word_o); endproperty
    a_wh: assert property (p_wh) else $error("partial");
endmodule

bind acd_config acd_config_chk chk_u (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .sel_n_i(sel_n_i), .ctrl_o(ctrl_o), .word_o(word_o));

// ### bench/acd_host_mdl.sv
`timescale 1ns/1ps
// Host shifting words MSB first; shift clock idles low between frames
module acd_host_mdl (
    input wire logic clock_i, // Clock
    output logic sel_n_o = 1'b1, // Select, low active
    output logic sclk_o = 1'b0, // Shift clock
    output logic sdi_o = 1'b0 // Data
);
    // Words come from the bench; 3-clock phases
    task automatic send(input logic [15:0] w, input int n);
        sel_n_o <= 1'b0;
        for (int i = 0; i < n; i++)
        begin
            sdi_o <= w[15-i];
            repeat (3) @(posedge clock_i);
            sclk_o <= 1'b1;
            repeat (3) @(posedge clock_i);
            sclk_o <= 1'b0;
        end
        repeat (3) @(posedge clock_i);
        sel_n_o <= 1'b1;
        sdi_o <= ~sdi_o; // Released line must not hold the last bit
        repeat (8) @(posedge clock_i);
    endtask
endmodule

// ### bench/amp_config_fault_decode_tb_top.sv
`timescale 1ns/1ps
// Whole, cut and random frames against expected controls
module amp_config_fault_decode_tb_top;
    import acd_pkg::*;
    logic clock_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic sel_n, sclk, sdi;
    logic sdo;
    acd_ctrl_s ctrl;
    logic [WORD_W-1:0] word;
    logic [15:0] seed = 16'h0040;
    logic [15:0] w;
    int miscompares = 0;
    int check_count = 0;
    // Fault sweep, then corners; 7000 probes the refused level
    logic [15:0] words[$] = '{16'h0082, 16'h00c2, 16'h5082, 16'h58c2, 16'h5000, 16'h0207,
        16'h0406, 16'h0818, 16'h1e26, 16'h2178, 16'h3f4f, 16'h4a10, 16'h6000, 16'h7000};

    always #50 clock_i = ~clock_i;

    acd_host_mdl host_u (.clock_i(clock_i), .sel_n_o(sel_n), .sclk_o(sclk), .sdi_o(sdi));
    acd_config dut_u (.clock_i(clock_i), .arst_n_i(arst_n_i), .clk_en_i(1'b1),
        .sel_n_i(sel_n), .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo), .ctrl_o(ctrl), .word_o(word));

    // Controls packed in struct order, then the word
    function automatic logic [36:0] expect_of(input logic [15:0] w);
        logic [2:0] v;
        logic on;
        v = w[14:12];
        on = v != 3'h0 && v < 3'h6;
        return {w[9], w[2:0] != 3'h7, w[10] | w[2:0] == 3'h7, w[11], v != 3'h0 && v != 3'h7,
            on, on ? 5'h1 << (v - 3'h1) : 5'h0, v == 3'h7, w[7:6], w[8],
            w[5] ? 3'h4 : {1'b0, w[4:3]}, w[2:0], w};
    endfunction

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input logic [36:0] seen, input logic [36:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (miscompares == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (8) @(posedge clock_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        chk({ctrl, word}, 37'h0);
        // Chain output shows the shift contents, which reset clears
        chk({36'h0, sdo}, 37'h0);
        foreach (words[i])
        begin
            w = words[i];
            host_u.send(w, 16);
            chk({ctrl, word}, expect_of(w));
            chk({21'h0, word}, {21'h0, w});
            // After a whole word the chain shows its top bit
            chk({36'h0, sdo}, {36'h0, w[15]});
        end
        host_u.send(16'hffff, 8);
        chk({ctrl, word}, expect_of(w));
        // Eight shifts moved the old low byte to the top; the word stays unapplied
        chk({36'h0, sdo}, {36'h0, w[7]});
        repeat (20)
        begin
            seed = lfsr_next(seed);
            w = seed;
            // Random words never carry level code 7
            if (w[14:12] == 3'h7)
                w[14] = 1'b0;
            host_u.send(w, 16);
            chk({ctrl, word}, expect_of(w));
        end
        summarize();
    end

    // 35 frames of at most 107 clocks; cut a hang well beyond that
    initial
    begin
        repeat (10000) @(posedge clock_i);
        miscompares++;
        summarize();
    end
endmodule

// ### hw/acd_config.sv
`timescale 1ns/1ps
// What this block does
// - Power-down bit one puts device in shutdown
// - Steps 0-6: filter switch follows ext-cap bit
// - Step 7 forces filter switch closed
// - Ext-cap select sits at bit ten
// - Target bit picks positive or negative input
// - Level code decodes source current, 111 banned
// - Step code bits 2:0, 7 is external
// - Route and invert fields in bits 8:6
// - Bandwidth trim field, five levels
module acd_config (
    input wire logic clock_i,                  // 10 MHz clock
    input wire logic arst_n_i,                 // Async reset, active low
    input wire logic clk_en_i,                 // Freezes state when low
    input wire logic sel_n_i,                  // Serial frame select pin, low active
    input wire logic sclk_i,                   // Serial shift clock pin
    input wire logic sdi_i,                    // Serial data pin
    output logic sdo_o,                        // Serial daisy-chain out
    output acd_pkg::acd_ctrl_s ctrl_o,         // Decoded analogue controls
    output logic [acd_pkg::WORD_W-1:0] word_o  // Applied control word
);
    import acd_pkg::*;

    logic [2:0] sel_meta_reg, sel_sync_reg;
    logic sclk_prev_reg;
    logic [WORD_W-1:0] word;
    logic load;
    acd_ctrl_s ctrl_next;

    // Pin synchronisers: first stage feeds only the second
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sel_meta_reg <= 3'h1;
            sel_sync_reg <= 3'h1;
            sclk_prev_reg <= 1'b0;
        end
        else if (clk_en_i)
        begin
            sel_meta_reg <= {sclk_i, sdi_i, sel_n_i};
            sel_sync_reg <= sel_meta_reg;
            sclk_prev_reg <= sel_sync_reg[2];
        end
    end

    acd_shift u_shift (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .clk_en_i(clk_en_i),
        .sel_n_i(sel_sync_reg[0]),
        .sclk_rise_i(sel_sync_reg[2] & ~sclk_prev_reg),
        .sdi_i(sel_sync_reg[1]),
        .word_o(word),
        .load_o(load),
        .sdo_o(sdo_o)
    );

    // Current level to one-hot strength; off/idle/illegal give none
    function automatic logic [4:0] level_onehot(input logic [LEVEL_W-1:0] code);
        logic [4:0] r;
        r = 5'h00;
        if (code != LEVEL_OFF && code < LEVEL_IDLE)
            r = 5'h01 << (code - 3'h1);
        return r;
    endfunction

    // Bandwidth code 1xx collapses to the heaviest level
    function automatic logic [2:0] trim_level(input logic [TRIM_W-1:0] code);
        logic [2:0] r;
        r = code[TRIM_W-1] ? 3'h4 : code;
        return r;
    endfunction

    // Decode of the staged word
    always_comb
    begin
        logic [STEP_W-1:0] step;
        logic [LEVEL_W-1:0] lvl;
        step = word[STEP_LSB +: STEP_W];
        lvl = word[LEVEL_LSB +: LEVEL_W];
        ctrl_next = '0;
        ctrl_next.power_down = word[SHUTDOWN_BIT];
        ctrl_next.amplification_step = step;
        ctrl_next.internal_ratio_switch = (step != STEP_EXTERNAL);
        if (step == STEP_EXTERNAL)
            ctrl_next.filter_path_switch = 1'b1;
        else
            ctrl_next.filter_path_switch = word[EXT_CAP_BIT];
        ctrl_next.bandwidth_level = trim_level(word[TRIM_LSB +: TRIM_W]);
        ctrl_next.route = acd_route_e'(word[ROUTE_LSB +: ROUTE_W]);
        ctrl_next.input_invert = word[INVERT_BIT];
        ctrl_next.source_to_negative = word[TARGET_BIT];
        // Source level decode; illegal code kept safe, flagged
        ctrl_next.source_level_onehot = level_onehot(lvl);
        ctrl_next.source_connected = (lvl != LEVEL_OFF) && (lvl < LEVEL_IDLE);
        ctrl_next.source_powered = (lvl != LEVEL_OFF) && (lvl != LEVEL_BAD);
        ctrl_next.level_code_illegal = (lvl == LEVEL_BAD);
    end

    // ctrl_o and word_o change together on load only
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ctrl_o <= '0;
            word_o <= WORD_RESET;
        end
        else if (clk_en_i && load)
        begin
            ctrl_o <= ctrl_next;
            word_o <= word;
        end
    end
endmodule

// ### hw/acd_pkg.sv
package acd_pkg;
    // Control word layout
    localparam int WORD_W = 16;
    localparam int STEP_LSB = 0;
    localparam int STEP_W = 3;
    localparam int TRIM_LSB = 3;
    localparam int TRIM_W = 3;
    localparam int ROUTE_LSB = 6;
    localparam int ROUTE_W = 2;
    localparam int INVERT_BIT = 8;
    localparam int SHUTDOWN_BIT = 9;
    localparam int EXT_CAP_BIT = 10;
    localparam int TARGET_BIT = 11;
    localparam int LEVEL_LSB = 12;
    localparam int LEVEL_W = 3;
    localparam int CNT_W = 5;
    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
    localparam logic [CNT_W-1:0] WORD_BITS = 5'h10;

    // Codes
    localparam logic [STEP_W-1:0] STEP_EXTERNAL = 3'h7;
    localparam logic [LEVEL_W-1:0] LEVEL_OFF = 3'h0;
    localparam logic [LEVEL_W-1:0] LEVEL_IDLE = 3'h6;
    localparam logic [LEVEL_W-1:0] LEVEL_BAD = 3'h7;

    typedef enum logic [1:0] {
        ACD_ROUTE_NORMAL,
        ACD_ROUTE_SHORTED,
        ACD_ROUTE_DIV_POS,
        ACD_ROUTE_DIV_NEG
    } acd_route_e;

    typedef struct packed {
        logic power_down;           // Low-power state
        logic internal_ratio_switch;
        logic filter_path_switch;
        logic source_to_negative;   // 1: source on negative input
        logic source_powered;
        logic source_connected;
        logic [4:0] source_level_onehot; // 10nA,100nA,1uA,10uA,100uA
        logic level_code_illegal;
        acd_route_e route;
        logic input_invert;
        logic [2:0] bandwidth_level; // 0..4
        logic [2:0] amplification_step;
    } acd_ctrl_s;
endpackage

// ### hw/acd_shift.sv
`timescale 1ns/1ps
// Serial shift register with bit counter; loads only whole words
module acd_shift (
    input wire logic clock_i,                      // 10 MHz clock
    input wire logic arst_n_i,                     // Async reset, active low
    input wire logic clk_en_i,                     // Freezes state when low
    input wire logic sel_n_i,                      // Synced frame select, low active
    input wire logic sclk_rise_i,                  // Synced shift clock rising edge
    input wire logic sdi_i,                        // Synced data in
    output logic [acd_pkg::WORD_W-1:0] word_o,     // Last complete word
    output logic load_o,                           // One-cycle load pulse
    output logic sdo_o                             // Daisy-chain output
);
    import acd_pkg::*;

    logic [WORD_W-1:0] shift_reg;
    logic [CNT_W-1:0] count_reg;
    logic sel_d_reg;

    // Shift while selected; MSB first, old MSB goes to the chain out
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            shift_reg <= WORD_RESET;
            count_reg <= '0;
        end
        else if (clk_en_i)
        begin
            if (sel_n_i)
                count_reg <= '0;
            else if (sclk_rise_i)
            begin
                shift_reg <= {shift_reg[WORD_W-2:0], sdi_i};
                if (count_reg != WORD_BITS)
                    count_reg <= count_reg + 5'h01;
            end
        end
    end

    // Latch on frame end, only after at least a full word was shifted
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sel_d_reg <= 1'b1;
            word_o <= WORD_RESET;
            load_o <= 1'b0;
            sdo_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            sel_d_reg <= sel_n_i;
            sdo_o <= shift_reg[WORD_W-1];
            load_o <= 1'b0;
            if (sel_n_i && !sel_d_reg && count_reg == WORD_BITS)
            begin
                word_o <= shift_reg;
                load_o <= 1'b1;
            end
        end
    end
endmodule
